// *** wdt_top.sv ***
// Watchdog timer with flags, power defaults and battery-low flag
// Behaviour
// - Five-bit multiplier above two resolution bits
// - Resolution codes: 1/16, 1/4, 1, 4 s
// - Timeout accurate within one resolution interval
// - Timeout sets flag, then interrupt or reset
// - Reading flags register clears timeout flag
// - Steer zero: interrupt output driven low
// - Steer one: single reset pulse, 40-200 ms
// - Reset-steered timeout clears watchdog and test enable
// - Register write or kick edge restarts period
// - All-zero watchdog register disables the timer
// - Interrupt held until zero written to watchdog or power-down
// - Power-down disables and clears watchdog register
// - Interrupt-steered watchdog or alarm enable beats test wave
// - Power-up clears listed control bits
// - Later power-up zeroes only listed bits
// - Power-down keeps alarm enables and stop bit, clears others
// - Power-up check sets battery-low below threshold
// - Battery-low holds until a good check
// - Battery checked only with main supply present
// - Test wave 512 Hz under five conditions
`timescale 1ns/1ps
module wdt_top #(
    parameter int RST_CYC  = wdt_pkg::RST_PULSE_CYC, // Reset pulse length in cycles
    parameter int CLK_RATE = wdt_pkg::CLK_HZ         // System clock rate in Hz
) (
    input  wire logic                      clk,          // 25 MHz clock
    input  wire logic                      arst_n,       // Async reset, active low
    input  wire logic [wdt_pkg::ADDR_W-1:0] addr,        // Register address
    input  wire logic [wdt_pkg::DATA_W-1:0] wdata,       // Write data
    input  wire logic                      wr,           // Write strobe
    input  wire logic                      rd,           // Read strobe
    output logic      [wdt_pkg::DATA_W-1:0] rdata,       // Read data, cycle after rd
    input  wire logic                      watchdog_kick_input, // Kick pin, async
    input  wire logic                      vcc_ok,       // Main supply nominal, async
    input  wire logic                      batt_low_cmp, // Battery below threshold, async
    input  wire logic                      alarm_event,  // Alarm match pulse, same clock
    output logic                           interrupt_freq_test_out_o,     // Interrupt/test pin output value
    output logic                           interrupt_freq_test_out_oe_n,  // Interrupt/test pin enable, low drives
    output logic                           rst_pin_o,    // Reset pin output value
    output logic                           rst_pin_oe_n  // Reset pin enable, low drives
);
    import wdt_pkg::*;

    // Control and status registers
    logic [7:0]  wd_q;          // Watchdog control register
    logic        wdf_q;         // Watchdog timeout flag
    logic        af_q;          // Alarm flag
    logic        bl_q;          // Battery low flag
    logic        afe_q;         // Alarm flag enable
    logic        abe_q;         // Alarm backup enable
    logic        cw_q;          // Clock write hold
    logic        cr_q;          // Clock read hold
    logic        stop_q;        // Oscillator stop
    logic        ft_q;          // Frequency test enable
    logic        wd_irq_q;      // Latched watchdog interrupt
    logic [7:0]  rdata_q;       // Read data register
    logic [31:0] rst_cnt_q;     // Reset pulse counter
    logic [6:0]  ticks_q;       // 1/16 s ticks within a unit
    logic [5:0]  units_q;       // Units elapsed
    logic        vcc_q;         // Previous supply level
    logic        irq_q;         // Pin drive low request
    logic        rstp_q;        // Reset pin drive low request

    // Synchronised pins and oscillator ticks
    logic kick_lvl;             // Filtered kick level
    logic kick_edge;            // Kick change pulse
    logic vcc_lvl;              // Filtered supply level
    logic bl_lvl;               // Filtered battery comparator
    logic tick16;               // 1/16 s tick
    logic sq512;                // 512 Hz wave

    edge_sync u_kick (
        .clk     (clk),
        .arst_n  (arst_n),
        .din     (watchdog_kick_input),
        .level   (kick_lvl),
        .toggled (kick_edge)
    );
    edge_sync u_vcc (
        .clk     (clk),
        .arst_n  (arst_n),
        .din     (vcc_ok),
        .level   (vcc_lvl),
        .toggled ()
    );
    edge_sync u_bl (
        .clk     (clk),
        .arst_n  (arst_n),
        .din     (batt_low_cmp),
        .level   (bl_lvl),
        .toggled ()
    );
    tick_gen #(
        .CLK_HZ (CLK_RATE),
        .OSC_HZ (OSC_HZ)
    ) u_tick (
        .clk     (clk),
        .arst_n  (arst_n),
        .osc_run (~stop_q),
        .tick16  (tick16),
        .sq512   (sq512)
    );

    // Ticks of 1/16 s per resolution code
    function automatic logic [6:0] res_ticks(input logic [1:0] code);
        case (code)
            2'b00:   res_ticks = 7'd1;   // 1/16 s
            2'b01:   res_ticks = 7'd4;   // 1/4 s
            2'b10:   res_ticks = 7'd16;  // 1 s
            default: res_ticks = 7'd64;  // 4 s
        endcase
    endfunction : res_ticks

    // Field decode
    wire       wd_steer           = wd_q[WD_STEER_BIT];
    wire [4:0] timeout_multiplier = wd_q[WD_MULT_LSB +: WD_MULT_W];
    wire [1:0] timeout_resolution = wd_q[WD_RES_LSB +: 2];
    wire       wd_enabled         = (wd_q != BYTE_ZERO) && (timeout_multiplier != 5'd0);

    // Address decode
    wire sel_flags = (addr == OFF_STATUS_FLAGS);
    wire sel_wd    = (addr == OFF_WATCHDOG_CTRL);
    wire sel_alarm = (addr == OFF_ALARM_CTRL);
    wire sel_clk   = (addr == OFF_CLOCK_CTRL);
    wire sel_sec   = (addr == OFF_SECONDS);
    wire sel_ft    = (addr == OFF_FTEST_CTRL);
    wire wr_wd     = wr && sel_wd;
    wire rd_flags  = rd && sel_flags;

    // Power events
    wire power_up   = vcc_lvl && !vcc_q;   // Main supply returns
    wire power_down = !vcc_lvl && vcc_q;   // Main supply lost

    // Timeout detection: units elapsed reaches multiplier
    wire unit_done  = tick16 && (ticks_q + 7'd1 >= res_ticks(timeout_resolution));
    wire timeout    = wd_enabled && vcc_lvl && unit_done &&
                      ({1'b0, units_q} + 6'd1 >= {1'b0, timeout_multiplier});
    wire restart    = wr_wd || kick_edge;
    wire rst_done   = rstp_q && (rst_cnt_q == 32'(RST_CYC - 1));

    // Pin drive requests
    wire irq_req = wd_irq_q || (af_q && afe_q);
    wire ft_wave = !stop_q && ft_q && !afe_q && (wd_steer || wd_q == BYTE_ZERO)
                   && !irq_req;
    wire irq_d   = irq_req || (ft_wave && !sq512);

    // Read data mux, unmapped reads return zero
    wire [7:0] rd_mux =
        sel_flags ? {wdf_q, af_q, 1'b0, bl_q, 4'h0} :
        sel_wd    ? wd_q :
        sel_alarm ? {afe_q, 1'b0, abe_q, 5'h00} :
        sel_clk   ? {cw_q, cr_q, 6'h00} :
        sel_sec   ? {stop_q, 7'h00} :
        sel_ft    ? {1'b0, ft_q, 6'h00} : BYTE_ZERO;

    // Supply edge tracker
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vcc_q <= 1'b0;
        end else begin
            vcc_q <= vcc_lvl;
        end
    end

    // Timeout counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ticks_q <= 7'd0;
            units_q <= 6'd0;
        end else if (restart || timeout || !wd_enabled) begin
            ticks_q <= 7'd0;
            units_q <= 6'd0;
        end else if (unit_done) begin
            ticks_q <= 7'd0;
            units_q <= units_q + 6'd1;
        end else if (tick16) begin
            ticks_q <= ticks_q + 7'd1;
        end
    end

    // Watchdog register and test enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_q <= WD_CTRL_RST;
            ft_q <= 1'b0;
        end else if (power_down || power_up) begin
            wd_q <= WD_CTRL_RST;
            ft_q <= 1'b0;
        end else if (rst_done) begin
            wd_q <= WD_CTRL_RST;
            ft_q <= 1'b0;
        end else begin
            if (wr_wd) begin
                wd_q <= wdata;
            end
            if (wr && sel_ft) begin
                ft_q <= wdata[FT_BIT];
            end
        end
    end

    // Alarm enables and clock holds
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            afe_q  <= 1'b0;
            abe_q  <= 1'b0;
            cw_q   <= 1'b0;
            cr_q   <= 1'b0;
            stop_q <= 1'b0;
        end else if (power_up) begin
            afe_q <= 1'b0;
            abe_q <= 1'b0;
            cw_q  <= 1'b0;
            cr_q  <= 1'b0;
        end else if (power_down) begin
            cw_q <= 1'b0;
            cr_q <= 1'b0;
        end else if (wr) begin
            if (sel_alarm) begin
                afe_q <= wdata[AFE_BIT];
                abe_q <= wdata[ABE_BIT];
            end
            if (sel_clk) begin
                cw_q <= wdata[CLK_WRITE_BIT];
                cr_q <= wdata[CLK_READ_BIT];
            end
            if (sel_sec) begin
                stop_q <= wdata[STOP_BIT];
            end
        end
    end

    // Flags: set wins over read-clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdf_q <= 1'b0;
            af_q  <= 1'b0;
            bl_q  <= 1'b0;
        end else begin
            if (timeout) begin
                wdf_q <= 1'b1;
            end else if (rd_flags) begin
                wdf_q <= 1'b0;
            end
            if (alarm_event) begin
                af_q <= 1'b1;
            end else if (rd_flags) begin
                af_q <= 1'b0;
            end
            if (power_up) begin
                bl_q <= bl_lvl;
            end
        end
    end

    // Interrupt latch, released only by writing zero or by power-down
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_irq_q <= 1'b0;
        end else if (timeout && !wd_steer) begin
            wd_irq_q <= 1'b1;
        end else if ((wr_wd && wdata == BYTE_ZERO) || power_down) begin
            wd_irq_q <= 1'b0;
        end
    end

    // Reset pulse generator
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstp_q    <= 1'b0;
            rst_cnt_q <= 32'h0000_0000;
        end else if (rst_done) begin
            rstp_q    <= 1'b0;
            rst_cnt_q <= 32'h0000_0000;
        end else if (rstp_q) begin
            rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
        end else if (timeout && wd_steer) begin
            rstp_q <= 1'b1;
        end
    end

    // Output registers and read data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q   <= 1'b0;
            rdata_q <= BYTE_ZERO;
        end else begin
            irq_q   <= irq_d;
            rdata_q <= rd ? rd_mux : BYTE_ZERO;
        end
    end

    assign rdata        = rdata_q;
    assign interrupt_freq_test_out_o     = 1'b0;
    assign interrupt_freq_test_out_oe_n  = ~irq_q;
    assign rst_pin_o    = 1'b0;
    assign rst_pin_oe_n = ~rstp_q;
endmodule : wdt_top

// *** wdt_pkg.sv ***
// Package with register map, field layout and timing constants of the watchdog block
package wdt_pkg;
    // Register offsets (byte addresses as printed)
    localparam logic [14:0] OFF_STATUS_FLAGS   = 15'h7ff0;
    localparam logic [14:0] OFF_WATCHDOG_CTRL  = 15'h7ff7;
    localparam logic [14:0] OFF_ALARM_CTRL     = 15'h7ff6;
    localparam logic [14:0] OFF_CLOCK_CTRL     = 15'h7ff8;
    localparam logic [14:0] OFF_SECONDS        = 15'h7ff9;
    localparam logic [14:0] OFF_FTEST_CTRL     = 15'h7ffc;
    localparam int          ADDR_W             = 15;
    localparam int          DATA_W             = 8;
    // Field positions
    localparam int          WD_STEER_BIT       = 7;
    localparam int          WD_MULT_LSB        = 2;
    localparam int          WD_MULT_W          = 5;
    localparam int          WD_RES_LSB         = 0;
    localparam int          FLAG_WDT_BIT       = 7;
    localparam int          FLAG_ALARM_BIT     = 6;
    localparam int          FLAG_BATT_BIT      = 4;
    localparam int          AFE_BIT            = 7;
    localparam int          ABE_BIT            = 5;
    localparam int          CLK_WRITE_BIT      = 7;
    localparam int          CLK_READ_BIT       = 6;
    localparam int          STOP_BIT           = 7;
    localparam int          FT_BIT             = 6;
    // Reset values
    localparam logic [7:0]  WD_CTRL_RST        = 8'h00;
    localparam logic [7:0]  BYTE_ZERO          = 8'h00;
    // Timing: clock and oscillator rates
    localparam int          CLK_HZ             = 25_000_000;
    localparam int          OSC_HZ             = 32_768;
    localparam int          OSC_PER_TICK       = 2048;           // One sixteenth second
    // Reset pulse width, chosen inside the window of 40 ms to 200 ms
    localparam int          RST_PULSE_MS       = 100;
    localparam int          RST_PULSE_CYC      = CLK_HZ / 1000 * RST_PULSE_MS;
    // Test square wave half period in oscillator cycles (512 Hz)
    localparam int          FT_HZ              = 512;
    localparam int          FT_HALF_OSC        = OSC_HZ / (2 * FT_HZ);
endpackage : wdt_pkg

// *** edge_sync.sv ***
// Three-stage input synchroniser with agreement-based change detect
`timescale 1ns/1ps
module edge_sync (
    input  wire logic clk,     // System clock
    input  wire logic arst_n,  // Async reset, active low
    input  wire logic din,     // Asynchronous pin
    output logic      level,   // Filtered level
    output logic      toggled  // One-cycle pulse on any change
);
    logic s1_q;  // First stage, feeds only s2
    logic s2_q;  // Second stage
    logic s3_q;  // Third stage
    logic lvl_q; // Accepted level
    wire  agree = (s2_q == s3_q); // Second and third agree

    // Shift chain and accepted level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            if (agree) begin
                lvl_q <= s3_q;
            end
        end
    end

    assign level   = lvl_q;
    assign toggled = agree && (s3_q != lvl_q);
endmodule : edge_sync

// *** tick_gen.sv ***
// Oscillator-derived tick generator: 1/16 s ticks and 512 Hz test wave
`timescale 1ns/1ps
module tick_gen #(
    parameter int CLK_HZ = 25_000_000, // System clock rate
    parameter int OSC_HZ = 32_768      // Oscillator rate
) (
    input  wire logic clk,        // System clock
    input  wire logic arst_n,     // Async reset, active low
    input  wire logic osc_run,    // Oscillator running
    output logic      tick16,     // One-cycle pulse every 1/16 s
    output logic      sq512       // 512 Hz square wave
);
    import wdt_pkg::*;
    logic [31:0] acc_q;   // Fractional accumulator for oscillator edges
    logic [10:0] div_q;   // Oscillator divider chain
    logic        tick_q;  // Registered tick
    wire  [31:0] acc_sum = acc_q + 32'(OSC_HZ);
    wire         osc_edge = osc_run && (acc_sum >= 32'(CLK_HZ));

    // Oscillator edge synthesis and divider chain
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q  <= 32'h0000_0000;
            div_q  <= 11'h000;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= osc_edge ? acc_sum - 32'(CLK_HZ) : (osc_run ? acc_sum : acc_q);
            if (osc_edge) begin
                div_q <= div_q + 11'h001;
            end
            tick_q <= osc_edge && (div_q == 11'(OSC_PER_TICK - 1));
        end
    end

    assign tick16 = tick_q;
    assign sq512  = div_q[$clog2(FT_HALF_OSC)];
endmodule : tick_gen

// *** wdt_top_assertions.sv ***
// Checker for register port and pin behaviour of the watchdog block
`timescale 1ns/1ps
module wdt_top_assertions
    import wdt_pkg::*;
#(
    parameter int RST_CYC = 20 // Reset pulse length in cycles
) (
    input wire logic                       clk,                 // Clock
    input wire logic                       arst_n,              // Async reset
    input wire logic [wdt_pkg::ADDR_W-1:0] addr,                // Address
    input wire logic [wdt_pkg::DATA_W-1:0] wdata,               // Write data
    input wire logic                       wr,                  // Write strobe
    input wire logic                       rd,                  // Read strobe
    input wire logic [wdt_pkg::DATA_W-1:0] rdata,               // Read data
    input wire logic                       watchdog_kick_input, // Kick pin
    input wire logic                       vcc_ok,              // Supply good
    input wire logic                       batt_low_cmp,        // Battery low
    input wire logic                       alarm_event,         // Alarm pulse
    input wire logic                       interrupt_freq_test_out_o,            // Irq pin value
    input wire logic                       interrupt_freq_test_out_oe_n,         // Irq pin enable
    input wire logic                       rst_pin_o,           // Reset pin value
    input wire logic                       rst_pin_oe_n         // Reset pin enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire        f_rd   = rd && addr == OFF_STATUS_FLAGS;  // Flags read
    wire        wd_rd  = rd && addr == OFF_WATCHDOG_CTRL; // Watchdog read
    wire        wd_wr  = wr && addr == OFF_WATCHDOG_CTRL; // Watchdog write
    wire        mapped = addr inside {OFF_STATUS_FLAGS, OFF_WATCHDOG_CTRL, OFF_ALARM_CTRL,
                                      OFF_CLOCK_CTRL, OFF_SECONDS, OFF_FTEST_CTRL};
    int         low_q; // Cycles the reset pin has been driven
    logic [3:0] dn_q;  // Cycles since supply loss, saturating
    logic [3:0] up_q;  // Cycles since supply return, saturating
    logic       bl_q;  // Battery state taken at power-up
    // Track supply phases, battery sample and reset pulse length
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_q <= 0;
            dn_q  <= 4'h0;
            up_q  <= 4'h0;
            bl_q  <= 1'b0;
        end else begin
            low_q <= rst_pin_oe_n ? 0 : low_q + 1;
            dn_q  <= vcc_ok ? 4'h0 : dn_q + {3'h0, dn_q != 4'hf};
            up_q  <= !vcc_ok ? 4'h0 : up_q + {3'h0, up_q != 4'hf};
            if (vcc_ok && up_q == 4'h0) begin
                bl_q <= batt_low_cmp; // Sample on each power-up
            end
        end
    end
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    unmapped_read_a: assert property (rd && !mapped |=> rdata == 8'h00)
        else $error("unmapped address read not zero");
    flags_reserved_a: assert property (f_rd |=> rdata[5] == 1'b0 && rdata[3:0] == 4'h0)
        else $error("reserved flag bits not zero");
    wd_readback_a: assert property (wd_wr && up_q[3] ##2 wd_rd |=> rdata == $past(wdata, 3))
        else $error("watchdog register readback wrong");
    wdf_read_clear_a: assert property (f_rd ##2 f_rd |=> rdata[FLAG_WDT_BIT] == 1'b0)
        else $error("timeout flag survived a flags read");
    reset_pulse_len_a: assert property ($rose(rst_pin_oe_n) |-> low_q == RST_CYC)
        else $error("reset pulse length wrong");
    powerdown_clear_a: assert property (dn_q[3] && wd_rd |=> rdata == 8'h00)
        else $error("watchdog register not cleared at power-down");
    battery_flag_a: assert property (up_q[3] && f_rd |=> rdata[FLAG_BATT_BIT] == bl_q)
        else $error("battery flag differs from power-up sample");
    pins_open_drain_a: assert property (interrupt_freq_test_out_o == 1'b0 && rst_pin_o == 1'b0)
        else $error("open-drain pin value not low");
endmodule : wdt_top_assertions

bind wdt_top wdt_top_assertions #(.RST_CYC(RST_CYC)) wdt_top_assertions_i (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .watchdog_kick_input(watchdog_kick_input), .vcc_ok(vcc_ok),
    .batt_low_cmp(batt_low_cmp), .alarm_event(alarm_event), .interrupt_freq_test_out_o(interrupt_freq_test_out_o),
    .interrupt_freq_test_out_oe_n(interrupt_freq_test_out_oe_n), .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n)
);

// *** host_model.sv ***
// Host side model: pull-ups on both open-drain pins and a reset counter
`timescale 1ns/1ps
module host_model (
    input  wire logic clk,          // Clock
    input  wire logic interrupt_freq_test_out_o,     // Irq pin value
    input  wire logic interrupt_freq_test_out_oe_n,  // Irq pin enable, low drives
    input  wire logic rst_pin_o,    // Reset pin value
    input  wire logic rst_pin_oe_n, // Reset pin enable, low drives
    output logic      irq_level,    // Irq wire seen by host
    output logic      rst_level,    // Reset wire seen by host
    output int        rst_count     // Resets taken
);
    logic rst_prev_q = 1'b1; // Last reset wire level
    // Released wires rise to the pull-up level
    assign irq_level = interrupt_freq_test_out_oe_n ? 1'b1 : interrupt_freq_test_out_o;
    assign rst_level = rst_pin_oe_n ? 1'b1 : rst_pin_o;
    initial rst_count = 0;
    // Each falling edge of the reset wire is one reset taken
    always @(posedge clk) begin
        if (rst_prev_q && !rst_level) begin
            rst_count <= rst_count + 1;
        end
        rst_prev_q <= rst_level;
    end
endmodule : host_model

// *** wdt_top_tb.sv ***
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
module wdt_top_tb;
    import wdt_pkg::*;
    localparam int     RC   = 20;                   // Short reset pulse
    localparam int     FHZ  = 4 * OSC_HZ;           // Scaled clock rate for short runs
    localparam int     HP   = FHZ / (2 * FT_HZ);    // Test wave half period
    localparam int     TICK = FHZ / 16;             // One sixteenth second
    logic              clk = 1'b0, arst_n = 1'b0;   // Clock and reset
    logic [ADDR_W-1:0] addr = '0;                   // Address
    logic [DATA_W-1:0] wdata = '0, rdata;           // Data
    logic              wr = 1'b0, rd = 1'b0;        // Strobes
    logic              kick = 1'b0, vcc = 1'b0, batt = 1'b0; // Pins in
    logic              irq_o, irq_oe_n, rst_o, rst_oe_n;     // Pins out
    logic              irq_level, rst_level;        // Resolved wires
    int                rst_count, mismatches = 0, check_count = 0;
    always #20 clk = ~clk;
    wdt_top #(.RST_CYC(RC), .CLK_RATE(FHZ)) wdt_top_i (.clk(clk), .arst_n(arst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .watchdog_kick_input(kick),
        .vcc_ok(vcc), .batt_low_cmp(batt), .alarm_event(1'b0), .interrupt_freq_test_out_o(irq_o),
        .interrupt_freq_test_out_oe_n(irq_oe_n), .rst_pin_o(rst_o), .rst_pin_oe_n(rst_oe_n));
    host_model host_model_i (.clk(clk), .interrupt_freq_test_out_o(irq_o), .interrupt_freq_test_out_oe_n(irq_oe_n),
        .rst_pin_o(rst_o), .rst_pin_oe_n(rst_oe_n), .irq_level(irq_level),
        .rst_level(rst_level), .rst_count(rst_count));
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : bus_wr
    task automatic fail(input string m);
        mismatches++;
        $display("mismatch at %0t: %s", $time, m);
    endtask : fail
    task automatic chk_rng(input int v, input int lo, input int hi, input string m);
        check_count++;
        if (v < lo || v > hi) begin
            fail($sformatf("%s %0d outside %0d..%0d", m, v, lo, hi));
        end
    endtask : chk_rng
    // Read one register and compare the masked answer
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] mk,
                          input logic [DATA_W-1:0] e, input string m);
        logic [DATA_W-1:0] d;
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata & mk;
        check_count++;
        if (d !== e) begin
            fail($sformatf("%s got %h want %h", m, d, e));
        end
    endtask : rd_chk
    task automatic pin_chk(input logic e, input string m);
        check_count++;
        if (irq_oe_n !== e) begin
            fail(m);
        end
    endtask : pin_chk
    task automatic wait_irq(input logic lvl, input int lim, output int n);
        n = 0;
        while (irq_oe_n !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_irq
    task automatic power(input logic lvl);
        @(posedge clk);
        vcc <= lvl;
        repeat (12) @(negedge clk);
    endtask : power
    // Power-up defaults, field layout, disable value, unmapped address
    task automatic t_defaults;
        power(1'b1);
        rd_chk(OFF_WATCHDOG_CTRL, 8'hff, 8'h00, "wd default");
        rd_chk(OFF_ALARM_CTRL, 8'ha0, 8'h00, "alarm default");
        rd_chk(OFF_CLOCK_CTRL, 8'hc0, 8'h00, "clock default");
        rd_chk(OFF_FTEST_CTRL, 8'h40, 8'h00, "ft default");
        for (int r = 0; r < 4; r++) begin
            bus_wr(OFF_WATCHDOG_CTRL, {6'h1f, r[1:0]});
            rd_chk(OFF_WATCHDOG_CTRL, 8'hff, {6'h1f, r[1:0]}, "wd field");
        end
        bus_wr(OFF_WATCHDOG_CTRL, 8'h00);
        rd_chk(OFF_WATCHDOG_CTRL, 8'hff, 8'h00, "wd off");
        bus_wr(15'h0100, 8'hff);
        rd_chk(15'h0100, 8'hff, 8'h00, "unmapped");
    endtask : t_defaults
    // Test wave runs at 512 Hz when enabled with the watchdog off
    task automatic t_wave;
        int n;
        bus_wr(OFF_FTEST_CTRL, 8'h40);
        wait_irq(1'b0, 60000, n);
        chk_rng(n, 0, 59999, "wave start");
        wait_irq(1'b1, 30000, n);
        wait_irq(1'b0, 30000, n);
        chk_rng(n, HP - HP / 50, HP + HP / 50, "wave half");
    endtask : t_wave
    // Interrupt- and reset-steered timeouts: wave denied, flag, hold, release, one reset pulse
    task automatic t_timeout;
        int n;
        int t;
        bus_wr(OFF_WATCHDOG_CTRL, 8'h08);
        repeat (4) @(negedge clk);
        pin_chk(1'b1, "wave not denied");
        repeat (5) begin
            wait_irq(1'b0, 4000, n);
            chk_rng(n, 4000, 4000, "pin low while armed");
            @(posedge clk);
            kick <= ~kick;
        end
        wait_irq(1'b0, 40000, t);
        chk_rng(t, TICK - 100, 3 * TICK + 100, "timeout");
        rd_chk(OFF_STATUS_FLAGS, 8'h80, 8'h80, "flag set");
        rd_chk(OFF_STATUS_FLAGS, 8'h80, 8'h00, "flag cleared");
        chk_rng(irq_level === 1'b0, 1, 1, "irq wire");
        bus_wr(OFF_FTEST_CTRL, 8'h00);
        repeat (100) @(negedge clk);
        pin_chk(1'b0, "irq dropped early");
        bus_wr(OFF_WATCHDOG_CTRL, 8'h00);
        repeat (4) @(negedge clk);
        pin_chk(1'b1, "irq not released");
        chk_rng(rst_count, 0, 0, "reset seen");
        bus_wr(OFF_FTEST_CTRL, 8'h40);
        bus_wr(OFF_WATCHDOG_CTRL, 8'h84);
        wait (rst_count != 0);
        repeat (RC + 4) @(negedge clk);
        chk_rng(rst_count, 1, 1, "pulses");
        rd_chk(OFF_WATCHDOG_CTRL, 8'hff, 8'h00, "wd cleared");
        rd_chk(OFF_FTEST_CTRL, 8'h40, 8'h00, "ft cleared");
    endtask : t_timeout
    // Power-down and power-up defaults, battery flag
    task automatic t_power;
        bus_wr(OFF_ALARM_CTRL, 8'ha0);
        bus_wr(OFF_WATCHDOG_CTRL, 8'h05);
        bus_wr(OFF_FTEST_CTRL, 8'h40);
        bus_wr(OFF_CLOCK_CTRL, 8'hc0);
        bus_wr(OFF_SECONDS, 8'h80);
        power(1'b0);
        rd_chk(OFF_WATCHDOG_CTRL, 8'hff, 8'h00, "wd down");
        rd_chk(OFF_FTEST_CTRL, 8'h40, 8'h00, "ft down");
        rd_chk(OFF_CLOCK_CTRL, 8'hc0, 8'h00, "clock down");
        rd_chk(OFF_ALARM_CTRL, 8'ha0, 8'ha0, "alarm down");
        @(posedge clk);
        batt <= 1'b1;
        power(1'b1);
        rd_chk(OFF_ALARM_CTRL, 8'ha0, 8'h00, "alarm up");
        rd_chk(OFF_SECONDS, 8'h80, 8'h80, "stop kept");
        rd_chk(OFF_STATUS_FLAGS, 8'h10, 8'h10, "batt set");
        @(posedge clk);
        batt <= 1'b0;
        repeat (12) @(negedge clk);
        rd_chk(OFF_STATUS_FLAGS, 8'h10, 8'h10, "batt held");
        power(1'b0);
        power(1'b1);
        rd_chk(OFF_STATUS_FLAGS, 8'h10, 8'h00, "batt cleared");
    endtask : t_power
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_defaults();
        t_wave();
        t_timeout();
        t_power();
        close_out();
    end
    // Cut a hang short
    initial begin
        repeat (80_000) @(posedge clk);
        fail("watchdog expired");
        close_out();
    end
endmodule : wdt_top_tb
